/* src/eeprom_pkg.sv */
package eeprom_pkg;

  // ***************************************************
  // geometry and codes
  // ***************************************************
  localparam int        BYTE_W     = 8;
  localparam int        EXT_W      = 3;
  localparam int        MEM_AW     = 11;
  localparam int        PAGE_AW    = 4;
  localparam int        PAGE_BYTES = 16;
  localparam logic [3:0] DEV_CODE  = 4'hA;
  localparam logic [7:0] ERASED    = 8'hFF;
  localparam logic [3:0] ACK_BIT   = 4'h8;

  // ***************************************************
  // timing
  // ***************************************************
  localparam int CLK_NS   = 40;
  localparam int T_WR_NS  = 4000000;
  // longest time: round down
  localparam int WR_CYC   = T_WR_NS / CLK_NS;
  localparam int SCL_QTR  = 4;

  // ***************************************************
  // states
  // ***************************************************
  typedef enum logic [5:0] {
    ST_IDLE  = 6'h01,
    ST_RX    = 6'h02,
    ST_NINTH = 6'h04,
    ST_TX    = 6'h08,
    ST_MACK  = 6'h10,
    ST_PROG  = 6'h20
  } dev_state_t;

  typedef enum logic [2:0] {
    K_DEV  = 3'h1,
    K_ADDR = 3'h2,
    K_DATA = 3'h4
  } byte_kind_t;

  typedef enum logic [4:0] {
    M_IDLE  = 5'h01,
    M_START = 5'h02,
    M_BIT   = 5'h04,
    M_LOW   = 5'h08,
    M_STOP  = 5'h10
  } mst_state_t;

endpackage

/* src/i2c_link_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface i2c_link_if;
  logic scl;
  logic m_sda_o;
  logic m_sda_oe_n;
  logic d_sda_o;
  logic d_sda_oe_n;
  logic sda;

  // open-drain wire with pull-up
  assign sda = ~((~m_sda_oe_n & ~m_sda_o) | (~d_sda_oe_n & ~d_sda_o));

  modport master (output scl, output m_sda_o, output m_sda_oe_n, input sda);
  modport dev    (input scl, input sda, output d_sda_o, output d_sda_oe_n);
endinterface
`default_nettype wire

/* src/pin_sync.sv */
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
  parameter int         W   = 1,
  parameter logic [W-1:0] RST = '0
) (
  input  wire logic         clk_sys,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_r;

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      meta_r <= RST;
      q      <= RST;
    end else begin
      meta_r <= d;
      q      <= meta_r;
    end
  end
endmodule
`default_nettype wire

/* src/eeprom_dev.sv */
`timescale 1ns/1ps
`default_nettype none
module eeprom_dev #(
  parameter int MEM_AW = eeprom_pkg::MEM_AW,
  parameter int WR_CYC = eeprom_pkg::WR_CYC
) (
  input  wire logic       clk_sys,
  input  wire logic       rst_n,
  i2c_link_if.dev         link,
  input  wire logic       wp,
  input  wire logic [2:0] chip_select_pins,
  output logic            busy
);
  import eeprom_pkg::*;

  // ***************************************************
  // pin sampling and bus events
  // ***************************************************
  logic       scl_s;
  logic       sda_s;
  logic       wp_s;
  logic [2:0] cs_s;
  logic       scl_q_r;
  logic       sda_q_r;

  pin_sync #(.W(6), .RST(6'h30)) u_sync (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .d       ({link.scl, link.sda, wp, chip_select_pins}),
    .q       ({scl_s, sda_s, wp_s, cs_s})
  );

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      scl_q_r <= 1'b1;
      sda_q_r <= 1'b1;
    end else begin
      scl_q_r <= scl_s;
      sda_q_r <= sda_s;
    end
  end

  logic scl_rise;
  logic scl_fall;
  logic start_c;
  logic stop_c;
  assign scl_rise = scl_s & ~scl_q_r;
  assign scl_fall = ~scl_s & scl_q_r;
  assign start_c  = scl_s & scl_q_r & sda_q_r & ~sda_s;
  assign stop_c   = scl_s & scl_q_r & ~sda_q_r & sda_s;

  // ***************************************************
  // state
  // ***************************************************
  localparam int DEPTH = 1 << MEM_AW;

  dev_state_t              st_r;
  byte_kind_t              kind_r;
  logic [3:0]              bit_cnt_r;
  logic [BYTE_W-1:0]       sh_r;
  logic                    dev_rw_r;
  logic [EXT_W-1:0]        hi_r;
  logic                    wp_lat_r;
  logic                    first_r;
  logic                    wrote_r;
  logic                    commit_r;
  logic                    sda_rel_r;
  logic                    busy_r;
  logic [31:0]             wr_cnt_r;
  logic [MEM_AW-1:0]       ptr_r;
  logic [PAGE_BYTES-1:0]   pvalid_r;
  logic [BYTE_W-1:0]       pbuf_r [PAGE_BYTES];
  logic [BYTE_W-1:0]       mem [DEPTH] = '{default: ERASED};
  logic [BYTE_W-1:0]       rd_byte;
  logic [BYTE_W+EXT_W-1:0] full_addr;
  logic                    byte_done;
  logic                    data_take;

  function automatic logic addr_match(input logic [7:0] b, input logic [2:0] cs);
    logic ok;
    ok = (b[7:4] == DEV_CODE);
    for (int i = 0; i < EXT_W; i++) begin
      if ((i + BYTE_W >= MEM_AW) && (b[i+1] != cs[i])) begin
        ok = 1'b0;
      end
    end
    return ok;
  endfunction

  assign rd_byte   = mem[ptr_r];
  assign full_addr = {hi_r, sh_r};
  assign byte_done = (st_r == ST_RX) & scl_fall & (bit_cnt_r == ACK_BIT) & ~start_c & ~stop_c;
  assign data_take = byte_done & (kind_r == K_DATA) & ~(first_r & wp_lat_r);
  assign link.d_sda_o    = sda_rel_r;
  assign link.d_sda_oe_n = sda_rel_r;
  assign busy            = busy_r;

  // ***************************************************
  // protocol engine
  // ***************************************************
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      st_r      <= ST_IDLE;
      kind_r    <= K_DEV;
      bit_cnt_r <= 4'h0;
      sh_r      <= 8'h00;
      dev_rw_r  <= 1'b0;
      hi_r      <= 3'h0;
      wp_lat_r  <= 1'b0;
      first_r   <= 1'b0;
      wrote_r   <= 1'b0;
      commit_r  <= 1'b0;
      sda_rel_r <= 1'b1;
      busy_r    <= 1'b0;
      wr_cnt_r  <= 32'h0;
      ptr_r     <= '0;
      pvalid_r  <= '0;
    end else begin
      commit_r <= 1'b0;
      if (st_r == ST_PROG) begin
        sda_rel_r <= 1'b1;
        wr_cnt_r  <= wr_cnt_r + 32'h1;
        if (wr_cnt_r == 32'(WR_CYC - 1)) begin
          st_r   <= ST_IDLE;
          busy_r <= 1'b0;
        end
      end else if (start_c) begin
        st_r      <= ST_RX;
        kind_r    <= K_DEV;
        bit_cnt_r <= 4'h0;
        sda_rel_r <= 1'b1;
        wrote_r   <= 1'b0;
        pvalid_r  <= '0;
      end else if (stop_c) begin
        sda_rel_r <= 1'b1;
        if (wrote_r) begin
          st_r     <= ST_PROG;
          commit_r <= 1'b1;
          busy_r   <= 1'b1;
          wr_cnt_r <= 32'h0;
          wrote_r  <= 1'b0;
        end else begin
          st_r <= ST_IDLE;
        end
      end else begin
        case (st_r)
          ST_RX: begin
            if (scl_rise) begin
              sh_r      <= {sh_r[6:0], sda_s};
              bit_cnt_r <= bit_cnt_r + 4'h1;
            end
            if (byte_done) begin
              sda_rel_r <= 1'b0;
              st_r      <= ST_NINTH;
              if (kind_r == K_DEV) begin
                if (addr_match(sh_r, cs_s)) begin
                  dev_rw_r <= sh_r[0];
                  hi_r     <= sh_r[3:1];
                  kind_r   <= K_ADDR;
                end else begin
                  sda_rel_r <= 1'b1;
                  st_r      <= ST_IDLE;
                end
              end else if (kind_r == K_ADDR) begin
                ptr_r   <= full_addr[MEM_AW-1:0];
                kind_r  <= K_DATA;
                first_r <= 1'b1;
              end else if (data_take) begin
                pvalid_r[ptr_r[PAGE_AW-1:0]] <= 1'b1;
                ptr_r   <= {ptr_r[MEM_AW-1:PAGE_AW], ptr_r[PAGE_AW-1:0] + 4'h1};
                wrote_r <= 1'b1;
                first_r <= 1'b0;
              end else begin
                sda_rel_r <= 1'b1;
                pvalid_r  <= '0;
                st_r      <= ST_IDLE;
              end
            end
          end
          ST_NINTH: begin
            if (scl_fall) begin
              if (kind_r == K_DATA && first_r && !dev_rw_r) begin
                wp_lat_r <= wp_s;
              end
              if (dev_rw_r) begin
                sh_r      <= rd_byte;
                sda_rel_r <= rd_byte[7];
                ptr_r     <= ptr_r + MEM_AW'(1);
                bit_cnt_r <= 4'h1;
                st_r      <= ST_TX;
              end else begin
                sda_rel_r <= 1'b1;
                bit_cnt_r <= 4'h0;
                st_r      <= ST_RX;
              end
            end
          end
          ST_TX: begin
            if (scl_fall) begin
              if (bit_cnt_r == ACK_BIT) begin
                sda_rel_r <= 1'b1;
                st_r      <= ST_MACK;
              end else begin
                sda_rel_r <= sh_r[6];
                sh_r      <= {sh_r[6:0], 1'b0};
                bit_cnt_r <= bit_cnt_r + 4'h1;
              end
            end
          end
          ST_MACK: begin
            if (scl_rise) begin
              st_r <= sda_s ? ST_IDLE : ST_NINTH;
            end
          end
          default: begin
          end
        endcase
      end
    end
  end

  // ***************************************************
  // page buffer and array
  // ***************************************************
  always_ff @(posedge clk_sys) begin
    if (data_take) begin
      pbuf_r[ptr_r[PAGE_AW-1:0]] <= sh_r;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (commit_r) begin
      for (int i = 0; i < PAGE_BYTES; i++) begin
        if (pvalid_r[i]) begin
          mem[{ptr_r[MEM_AW-1:PAGE_AW], PAGE_AW'(i)}] <= pbuf_r[i];
        end
      end
    end
  end
endmodule
`default_nettype wire

/* src/i2c_master_end.sv */
`timescale 1ns/1ps
`default_nettype none
module i2c_master_end #(
  parameter int QTR = eeprom_pkg::SCL_QTR
) (
  input  wire logic       clk_sys,
  input  wire logic       rst_n,
  i2c_link_if.master      link,
  input  wire logic       cmd_valid,
  input  wire logic       cmd_start,
  input  wire logic       cmd_stop,
  input  wire logic       cmd_read,
  input  wire logic       cmd_nack,
  input  wire logic [7:0] cmd_wdata,
  output logic            cmd_ready,
  output logic            rsp_valid,
  output logic            rsp_ack,
  output logic [7:0]      rsp_rdata
);
  import eeprom_pkg::*;

  // ***************************************************
  // quarter-period timebase
  // ***************************************************
  mst_state_t  st_r;
  logic [15:0] qcnt_r;
  logic        tick;
  logic [1:0]  ph_r;
  logic [3:0]  bit_r;
  logic [7:0]  tx_r;
  logic        rd_r;
  logic        nack_r;
  logic        stop_r;
  logic        scl_r;
  logic        sda_rel_r;
  logic        sda_s;

  pin_sync #(.W(1), .RST(1'h1)) u_sync (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .d       (link.sda),
    .q       (sda_s)
  );

  assign tick            = (qcnt_r == 16'(QTR - 1));
  assign link.scl        = scl_r;
  assign link.m_sda_o    = sda_rel_r;
  assign link.m_sda_oe_n = sda_rel_r;

  always_ff @(posedge clk_sys) begin
    if (!rst_n || st_r == M_IDLE || tick) begin
      qcnt_r <= 16'h0;
    end else begin
      qcnt_r <= qcnt_r + 16'h1;
    end
  end

  // ***************************************************
  // bit sequencer
  // ***************************************************
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      st_r      <= M_IDLE;
      ph_r      <= 2'h0;
      bit_r     <= 4'h0;
      tx_r      <= 8'hFF;
      rd_r      <= 1'b0;
      nack_r    <= 1'b0;
      stop_r    <= 1'b0;
      scl_r     <= 1'b1;
      sda_rel_r <= 1'b1;
      cmd_ready <= 1'b1;
      rsp_valid <= 1'b0;
      rsp_ack   <= 1'b0;
      rsp_rdata <= 8'h00;
    end else begin
      rsp_valid <= 1'b0;
      case (st_r)
        M_IDLE: begin
          if (cmd_valid && cmd_ready) begin
            cmd_ready <= 1'b0;
            tx_r      <= cmd_read ? 8'hFF : cmd_wdata;
            rd_r      <= cmd_read;
            nack_r    <= cmd_nack;
            stop_r    <= cmd_stop;
            ph_r      <= 2'h0;
            bit_r     <= 4'h0;
            st_r      <= cmd_start ? M_START : M_BIT;
          end
        end
        M_START: begin
          if (tick) begin
            ph_r <= ph_r + 2'h1;
            case (ph_r)
              2'h0: sda_rel_r <= 1'b1;
              2'h1: scl_r <= 1'b1;
              2'h2: sda_rel_r <= 1'b0;
              default: st_r <= M_BIT;
            endcase
          end
        end
        M_BIT: begin
          if (tick) begin
            ph_r <= ph_r + 2'h1;
            case (ph_r)
              2'h0: scl_r <= 1'b0;
              2'h1: sda_rel_r <= (bit_r == ACK_BIT) ? (rd_r ? nack_r : 1'b1) : tx_r[7];
              2'h2: scl_r <= 1'b1;
              default: begin
                if (bit_r == ACK_BIT) begin
                  rsp_ack <= ~sda_s;
                  st_r    <= M_LOW;
                end else begin
                  rsp_rdata <= {rsp_rdata[6:0], sda_s};
                  tx_r      <= {tx_r[6:0], 1'b1};
                end
                bit_r <= bit_r + 4'h1;
              end
            endcase
          end
        end
        M_LOW: begin
          if (tick) begin
            scl_r <= 1'b0;
            ph_r  <= 2'h0;
            if (stop_r) begin
              st_r <= M_STOP;
            end else begin
              st_r      <= M_IDLE;
              cmd_ready <= 1'b1;
              rsp_valid <= 1'b1;
            end
          end
        end
        M_STOP: begin
          if (tick) begin
            ph_r <= ph_r + 2'h1;
            case (ph_r)
              2'h0: sda_rel_r <= 1'b0;
              2'h1: scl_r <= 1'b1;
              2'h2: sda_rel_r <= 1'b1;
              default: begin
                st_r      <= M_IDLE;
                cmd_ready <= 1'b1;
                rsp_valid <= 1'b1;
              end
            endcase
          end
        end
        default: st_r <= M_IDLE;
      endcase
    end
  end
endmodule
`default_nettype wire

/* sim/serial_eeprom_rw_engine_props.sv */
`timescale 1ns/1ps
`default_nettype none
module serial_eeprom_rw_engine_props #(
  parameter int WR_CYC = 200
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic scl,
  input wire logic sda,
  input wire logic d_sda_o,
  input wire logic d_sda_oe_n,
  input wire logic wp,
  input wire logic busy
);
  logic [19:0] busy_cnt_r;
  logic [7:0]  since_stop_r;
  logic [9:0]  wp_hi_r;
  logic [3:0]  bit_cnt_r;
  logic        scl_q_r;
  logic        sda_q_r;

  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  always_ff @(posedge clk_sys) begin
    scl_q_r <= !rst_n | scl;
    sda_q_r <= !rst_n | sda;
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n || !busy) busy_cnt_r <= '0;
    else busy_cnt_r <= busy_cnt_r + 20'h00001;
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) since_stop_r <= 8'hFF;
    else if (scl && scl_q_r && sda && !sda_q_r) since_stop_r <= 8'h00;
    else if (since_stop_r != 8'hFF) since_stop_r <= since_stop_r + 8'h01;
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n || !wp) wp_hi_r <= '0;
    else if (wp_hi_r != 10'h3FF) wp_hi_r <= wp_hi_r + 10'h001;
  end

  // scl rises since the last start
  always_ff @(posedge clk_sys) begin
    if (!rst_n) bit_cnt_r <= 4'hF;
    else if (scl && scl_q_r && !sda && sda_q_r) bit_cnt_r <= 4'h0;
    else if (scl && !scl_q_r && bit_cnt_r != 4'hF) bit_cnt_r <= bit_cnt_r + 4'h1;
  end

  a_busy_sda_free: assert property (busy |-> d_sda_oe_n)
    else $error("device drives sda while busy");
  a_busy_len_cap: assert property (busy |-> busy_cnt_r < WR_CYC)
    else $error("write cycle too long");
  a_commit_on_stop: assert property ($rose(busy) |-> since_stop_r < 8'd16)
    else $error("write cycle without stop");
  a_wp_blocks_write: assert property ($rose(busy) |-> wp_hi_r < 10'd400)
    else $error("write cycle while protected");
  a_sda_change_low: assert property ($changed(d_sda_oe_n) |-> !scl)
    else $error("device sda change with scl high");
  a_ack_holds: assert property ($fell(d_sda_oe_n) |=> !d_sda_oe_n [*8])
    else $error("device low bit too short");
  a_ack_ninth: assert property ($fell(d_sda_oe_n) && bit_cnt_r < 4'd9 |-> bit_cnt_r == 4'd8)
    else $error("device ack outside ninth clock");
  a_addr_quiet: assert property (bit_cnt_r < 4'd8 |-> d_sda_oe_n)
    else $error("device drives during slave address");
  a_stop_standby: assert property (since_stop_r == 8'd10 |-> d_sda_oe_n)
    else $error("device drives after stop");

  c_write_cycle: cover property ($rose(busy));
  c_dev_pulls: cover property ($fell(d_sda_oe_n));
  c_wp_stop: cover property (wp && since_stop_r == 8'd0);
endmodule
`default_nettype wire

/* sim/serial_eeprom_rw_engine_bench.sv */
`timescale 1ns/1ps
`default_nettype none
module serial_eeprom_rw_engine_bench;
  import eeprom_pkg::*;
  localparam int WRC = 200;
  typedef struct {logic [10:0] a; logic [7:0] d; logic [7:0] e;} row_t;
  logic       clk_sys = 1'b0;
  logic       rst_n = 1'b0;
  logic       wp = 1'b0;
  logic       cmd_valid = 1'b0;
  logic       cmd_start = 1'b0;
  logic       cmd_stop = 1'b0;
  logic       cmd_read = 1'b0;
  logic       cmd_nack = 1'b0;
  logic [7:0] cmd_wdata = 8'h00;
  logic       cmd_ready;
  logic       rsp_valid;
  logic       rsp_ack;
  logic [7:0] rsp_rdata;
  logic       busy;
  logic [7:0] mem [2048];
  int         err_count = 0;
  int         checks = 0;
  int         cyc = 0;
  row_t       rows [4] = '{'{11'h123, 8'h55, 8'h55}, '{11'h000, 8'h00, 8'h00},
                           '{11'h3F0, 8'h3C, 8'h3C}, '{11'h7FF, 8'hA5, 8'hA5}};

  i2c_link_if link();
  i2c_master_end i2c_master_end_i (.clk_sys(clk_sys), .rst_n(rst_n), .link(link), .cmd_valid(cmd_valid),
    .cmd_start(cmd_start), .cmd_stop(cmd_stop), .cmd_read(cmd_read), .cmd_nack(cmd_nack),
    .cmd_wdata(cmd_wdata), .cmd_ready(cmd_ready), .rsp_valid(rsp_valid), .rsp_ack(rsp_ack),
    .rsp_rdata(rsp_rdata));
  eeprom_dev #(.WR_CYC(WRC)) eeprom_dev_i (.clk_sys(clk_sys), .rst_n(rst_n), .link(link), .wp(wp),
    .chip_select_pins(3'h0), .busy(busy));
  serial_eeprom_rw_engine_props #(.WR_CYC(WRC)) serial_eeprom_rw_engine_props_i (.clk_sys(clk_sys),
    .rst_n(rst_n), .scl(link.scl), .sda(link.sda), .d_sda_o(link.d_sda_o),
    .d_sda_oe_n(link.d_sda_oe_n), .wp(wp), .busy(busy));

  always #20 clk_sys = ~clk_sys;

  // ***************************************************
  // tasks
  // ***************************************************
  task report_and_stop;
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 60000) begin
      err_count++;
      report_and_stop();
    end
  end

  task chk_bit(input string nm, input logic e, input logic g);
    checks++;
    if (g !== e) begin
      err_count++;
      $display("FAIL %s exp %b got %b", nm, e, g);
    end
  endtask

  task chk_byte(input string nm, input logic [7:0] e, input logic [7:0] g);
    checks++;
    if (g !== e) begin
      err_count++;
      $display("FAIL %s exp %h got %h", nm, e, g);
    end
  endtask

  // one byte on the link; entered just after an edge
  task xfer(input logic st, input logic sp, input logic rd, input logic nk, input logic [7:0] d);
    int k;
    while (cmd_ready !== 1'b1) begin
      @(posedge clk_sys);
      #1;
    end
    cmd_start = st;
    cmd_stop = sp;
    cmd_read = rd;
    cmd_nack = nk;
    cmd_wdata = d;
    cmd_valid = 1'b1;
    @(posedge clk_sys);
    #1 cmd_valid = 1'b0;
    k = 0;
    do begin
      @(posedge clk_sys);
      #1;
      k++;
    end while (rsp_valid !== 1'b1 && k < 600);
    chk_bit("rsp_valid", 1'b1, rsp_valid);
  endtask

  task poll;
    int k;
    k = 0;
    xfer(1'b1, 1'b1, 1'b0, 1'b0, {DEV_CODE, 4'h0});
    chk_bit("poll_busy", 1'b0, rsp_ack);
    do begin
      xfer(1'b1, 1'b1, 1'b0, 1'b0, {DEV_CODE, 4'h0});
      k++;
    end while (rsp_ack !== 1'b1 && k < 8);
    chk_bit("poll_done", 1'b1, rsp_ack);
  endtask

  task put(input logic [10:0] a, input int cnt, input logic [7:0] b);
    logic [10:0] q;
    q = a;
    xfer(1'b1, 1'b0, 1'b0, 1'b0, {DEV_CODE, a[10:8], 1'b0});
    chk_bit("wr_dev_ack", 1'b1, rsp_ack);
    xfer(1'b0, 1'b0, 1'b0, 1'b0, a[7:0]);
    chk_bit("wr_word_ack", 1'b1, rsp_ack);
    for (int i = 0; i < cnt; i++) begin
      xfer(1'b0, i == cnt - 1, 1'b0, 1'b0, b + 8'(i));
      chk_bit("wr_data_ack", 1'b1, rsp_ack);
      mem[q] = b + 8'(i);
      q = {q[10:4], q[3:0] + 4'h1};
    end
    chk_bit("busy_wr", 1'b1, busy);
    poll();
    chk_bit("busy_end", 1'b0, busy);
  endtask

  task get(input logic [10:0] a, input int cnt);
    logic [10:0] q;
    q = a;
    xfer(1'b1, 1'b0, 1'b0, 1'b0, {DEV_CODE, a[10:8], 1'b0});
    xfer(1'b0, 1'b0, 1'b0, 1'b0, a[7:0]);
    xfer(1'b1, 1'b0, 1'b0, 1'b0, {DEV_CODE, a[10:8], 1'b1});
    chk_bit("rd_ack", 1'b1, rsp_ack);
    for (int i = 0; i < cnt; i++) begin
      xfer(1'b0, i == cnt - 1, 1'b1, i == cnt - 1, 8'h00);
      chk_byte("rd_data", mem[q], rsp_rdata);
      q = q + 11'h001;
    end
  endtask

  task imm(input logic [7:0] e);
    xfer(1'b1, 1'b0, 1'b0, 1'b0, {DEV_CODE, 4'h1});
    chk_bit("imm_ack", 1'b1, rsp_ack);
    xfer(1'b0, 1'b1, 1'b1, 1'b1, 8'h00);
    chk_byte("imm_data", e, rsp_rdata);
  endtask

  // ***************************************************
  // sequence
  // ***************************************************
  initial begin
    foreach (mem[i]) mem[i] = ERASED;
    repeat (2) @(posedge clk_sys);
    #1 rst_n = 1'b1;
    chk_bit("busy_rst", 1'b0, busy);
    chk_bit("ready_rst", 1'b1, cmd_ready);
    chk_bit("sda_idle", 1'b1, link.sda);
    imm(ERASED);
    $display("test reset done");
    foreach (rows[i]) begin
      put(rows[i].a, 1, rows[i].d);
      get(rows[i].a, 1);
      chk_byte("row_data", rows[i].e, rsp_rdata);
    end
    $display("test rows done");
    imm(8'h00);
    put(11'h20E, 18, 8'h10);
    get(11'h1FF, 18);
    get(11'h7FE, 3);
    $display("test page done");
    wp = 1'b1;
    xfer(1'b1, 1'b0, 1'b0, 1'b0, {DEV_CODE, 3'h3, 1'b0});
    xfer(1'b0, 1'b0, 1'b0, 1'b0, 8'h00);
    chk_bit("wp_word_ack", 1'b1, rsp_ack);
    xfer(1'b0, 1'b1, 1'b0, 1'b0, 8'h77);
    chk_bit("wp_data_ack", 1'b0, rsp_ack);
    chk_bit("wp_no_busy", 1'b0, busy);
    xfer(1'b1, 1'b1, 1'b0, 1'b0, {DEV_CODE, 4'h0});
    chk_bit("wp_idle", 1'b1, rsp_ack);
    wp = 1'b0;
    get(11'h300, 1);
    $display("test protect done");
    xfer(1'b1, 1'b1, 1'b0, 1'b0, 8'hB0);
    chk_bit("bad_dev", 1'b0, rsp_ack);
    rst_n = 1'b0;
    repeat (3) @(posedge clk_sys);
    #1 rst_n = 1'b1;
    chk_bit("busy_rst2", 1'b0, busy);
    chk_bit("ready_rst2", 1'b1, cmd_ready);
    imm(mem[0]);
    $display("test misc done");
    report_and_stop();
  end
endmodule
`default_nettype wire
